// ==== ssp_monitor.sv ====
// port-level assertion checker for the soft switch panel
`timescale 1ns/1ps
`default_nettype none
module ssp_monitor #(
   parameter logic [15:0] BAUD_CYCLES = 16'h0008
) (
   input wire logic              CORE_CLK,
   input wire logic              SYS_RST,
   input wire logic              RESET_KEY_A,
   input wire logic              RESET_KEY_B,
   input wire logic [7:0]        INDICATOR,
   input wire logic              STORE_REQ,
   input wire logic [23:0]       STORE_DATA,
   input wire logic              STORE_ERR,
   input wire logic              BATT_LOW,
   input wire logic              CONSOLE_MSG,
   input wire logic              PANEL_RESET,
   input wire logic [4:0]        CHAN_COUNT,
   input wire logic [15:0]       CTL_DRIVEN,
   input wire logic [15:0]       CTL_LEVEL,
   input wire logic [15:0]       CTL_STATE,
   input wire logic              BAUD_TICK,
   input wire ssp_pkg::ssp_cfg_t CFG
);
   logic [1:0]  up;
   logic [15:0] bc;
   logic        seen;
   wire         fault = STORE_ERR | BATT_LOW;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   // settle count after reset and spacing of rate ticks
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         up <= 2'h0;
         bc <= 16'h0000;
         seen <= 1'b0;
      end else begin
         if (up != 2'h3) up <= up + 2'h1;
         bc <= BAUD_TICK ? 16'h0001 : bc + 16'h0001;
         if (BAUD_TICK) seen <= 1'b1;
      end
   end
   a_fault_msg: assert property ($rose(fault) |=> CONSOLE_MSG)
      else $error("no console message after fault");
   a_msg_cause: assert property (CONSOLE_MSG |-> $past(fault) && !$past(fault, 2))
      else $error("console message without fault edge");
   a_panel_lamps: assert property (PANEL_RESET |-> INDICATOR == 8'hFF)
      else $error("indicators not all lit in panel reset");
   a_panel_commit: assert property ($rose(PANEL_RESET) |-> STORE_REQ)
      else $error("panel reset without commit");
   a_reset_keys: assert property (up == 2'h3 && !PANEL_RESET && !$past(PANEL_RESET)
      && $rose(RESET_KEY_A && RESET_KEY_B) |=> PANEL_RESET)
      else $error("reset keys ignored");
   a_baud_period: assert property (seen |-> BAUD_TICK == (bc == BAUD_CYCLES))
      else $error("rate tick spacing wrong");
   a_ctl_bias: assert property (up == 2'h3 && $stable(CTL_DRIVEN) && $stable(CTL_LEVEL)
      && $stable(CFG.bias_en) |-> CTL_STATE
      == ((CTL_DRIVEN & CTL_LEVEL) | (~CTL_DRIVEN & CFG.bias_en)))
      else $error("control input state wrong");
   a_bank_map: assert property (up == 2'h3 && $stable(STORE_DATA) |-> CFG.bias_en
      == {{6{STORE_DATA[23]}}, {6{STORE_DATA[22]}}, {4{STORE_DATA[21]}}})
      else $error("bias bank mapping wrong");
   a_seq_modes: assert property (up == 2'h3 && $stable(STORE_DATA) |->
      CFG.pkt_mod128 == STORE_DATA[4] && CFG.frm_mod128 == STORE_DATA[6]
      && CFG.dce_role == STORE_DATA[7] && CFG.cold_start == STORE_DATA[3])
      else $error("mode selections not applied");
   a_lcn_range: assert property (up == 2'h3 && $stable(CFG.lgn) |->
      CFG.lcn_first == (CFG.lgn == 4'h0 ? 5'h01 : 5'h00) && CFG.lcn_last
      == CHAN_COUNT + (CFG.lgn == 4'h0 ? 5'h02 : 5'h01))
      else $error("channel number range wrong");
   c_panel: cover property ($rose(PANEL_RESET));
   c_msg: cover property (CONSOLE_MSG);
   c_expiry: cover property (STORE_REQ && !PANEL_RESET);
endmodule // ssp_monitor
bind ssp_panel ssp_monitor #(.BAUD_CYCLES(BAUD_CYCLES)) u_mon (
   .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .RESET_KEY_A(RESET_KEY_A),
   .RESET_KEY_B(RESET_KEY_B), .INDICATOR(INDICATOR), .STORE_REQ(STORE_REQ),
   .STORE_DATA(STORE_DATA), .STORE_ERR(STORE_ERR), .BATT_LOW(BATT_LOW),
   .CONSOLE_MSG(CONSOLE_MSG), .PANEL_RESET(PANEL_RESET), .CHAN_COUNT(CHAN_COUNT),
   .CTL_DRIVEN(CTL_DRIVEN), .CTL_LEVEL(CTL_LEVEL), .CTL_STATE(CTL_STATE),
   .BAUD_TICK(BAUD_TICK), .CFG(CFG));
`default_nettype wire

// ==== ssp_nv_model.sv ====
// storage partner: battery backed image behind the commit port
`timescale 1ns/1ps
`default_nettype none
module ssp_nv_model (
   input  wire logic        CORE_CLK,
   input  wire logic        STORE_REQ,
   input  wire logic [23:0] STORE_DATA,
   output wire logic [23:0] NV_IMAGE
);
   logic [23:0] mem = 24'h000000;
   // image survives system reset, only a commit changes it
   always @(posedge CORE_CLK) begin
      if (STORE_REQ) mem <= STORE_DATA;
   end
   assign NV_IMAGE = mem;
endmodule // ssp_nv_model
`default_nettype wire

// ==== ssp_panel.sv ====
// soft switch panel: keys, indicators, timeout, storage commit and bus access
// How it works
// - group key shows that group on indicators
// - group key starts 25 second timeout
// - any further group or numeric key reloads full timeout
// - expiry returns indicators to status display
// - expiry commits settings to nonvolatile storage
// - numeric key k toggles selection k
// - selection k always on indicator k
// - both reset keys reset and commit settings
// - all indicators lit during panel reset
// - storage fault raises console message request
// - cold start bit restores factory settings
// - group one selection 5 picks packet modulus
// - group one selection 7 picks frame modulus
// - group one selection 8 picks DCE role
// - default group zero, channels 1..n+2
// - group two 1..4 of the stored image give group number, on cold start load only
// - nonzero group uses channels 0..n+1
// - bias selections default off
// - clocking rate fixed at 9600 bps
// - undriven input reads bias, driven reads level
// - bias applies per channel bank
`timescale 1ns/1ps
`default_nettype none

module ssp_panel #(
   parameter logic [31:0] TIMEOUT_CYCLES = ssp_pkg::TIMEOUT_CYC,
   parameter logic [15:0] BAUD_CYCLES    = ssp_pkg::BAUD_CYC
) (
   input  wire logic                  CORE_CLK,
   input  wire logic                  SYS_RST,
   input  wire ssp_pkg::ssp_axi_req_t AXI_REQ,
   output var  ssp_pkg::ssp_axi_rsp_t AXI_RSP,
   input  wire logic [2:0]            GROUP_KEY,
   input  wire logic [7:0]            NUM_KEY,
   input  wire logic                  RESET_KEY_A,
   input  wire logic                  RESET_KEY_B,
   input  wire logic [7:0]            STATUS_IND,
   output logic      [7:0]            INDICATOR,
   input  wire logic [23:0]           NV_IMAGE,
   output logic                       STORE_REQ,
   output logic      [23:0]           STORE_DATA,
   input  wire logic                  STORE_ERR,
   input  wire logic                  BATT_LOW,
   output logic                       CONSOLE_MSG,
   output logic                       PANEL_RESET,
   input  wire logic [4:0]            CHAN_COUNT,
   input  wire logic [15:0]           CTL_DRIVEN,
   input  wire logic [15:0]           CTL_LEVEL,
   output logic      [15:0]           CTL_STATE,
   output logic                       BAUD_TICK,
   output var  ssp_pkg::ssp_cfg_t     CFG
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // lowest pressed group key wins
   function automatic logic [1:0] first_key(input logic [2:0] k);
      logic [1:0] r;
      r = 2'h0;
      if (k[1] && !k[0])
         r = 2'h1;
      if (k[2] && !k[1] && !k[0])
         r = 2'h2;
      return r;
   endfunction

   // expand three bank enables to sixteen channels
   function automatic logic [15:0] bias_map(input logic [7:0] g3);
      logic [15:0] b;
      b = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         if (i <= ssp_pkg::BANK_A_END)
            b[i] = g3[ssp_pkg::SEL_BIAS_A];
         else if (i <= ssp_pkg::BANK_B_END)
            b[i] = g3[ssp_pkg::SEL_BIAS_B];
         else
            b[i] = g3[ssp_pkg::SEL_BIAS_C];
      end
      return b;
   endfunction

   // register read mux, shared by nothing else but kept apart for clarity
   function automatic logic [31:0] read_word(input ssp_pkg::ssp_state_t s,
                                             input logic [3:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (a)
         ssp_pkg::REG_SETTINGS: d[23:0] = s.grp;
         ssp_pkg::REG_STATUS: begin
            d[ssp_pkg::STAT_EDIT]           = (s.mode == ssp_pkg::ST_EDIT);
            d[ssp_pkg::STAT_GRP +: 2]       = s.sel;
            d[ssp_pkg::STAT_PRST]           = (s.mode == ssp_pkg::ST_PANEL_RST);
            d[ssp_pkg::STAT_ERR]            = s.err_flag;
         end
         ssp_pkg::REG_CIRCUIT: d[13:0] = {s.cfg.lcn_last, s.cfg.lcn_first, s.cfg.lgn};
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   function automatic logic mapped(input logic [3:0] a);
      return (a == ssp_pkg::REG_SETTINGS) || (a == ssp_pkg::REG_STATUS) ||
             (a == ssp_pkg::REG_CIRCUIT);
   endfunction

   ssp_pkg::ssp_state_t st;
   ssp_pkg::ssp_state_t next_st;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [2:0] g_press;
      logic [7:0] k_press;
      logic       r_both;
      logic       fault;
      g_press = 3'h0;
      k_press = 8'h00;
      r_both  = 1'b0;
      fault   = 1'b0;
      next_st = st;
      next_st.store_req = 1'b0;
      next_st.con_msg   = 1'b0;
      next_st.baud_tick = 1'b0;

      // key edges, inputs are synchronous
      g_press = GROUP_KEY & ~st.gkey_q;
      k_press = NUM_KEY & ~st.nkey_q;
      r_both  = RESET_KEY_A & RESET_KEY_B;
      fault   = STORE_ERR | BATT_LOW;
      next_st.gkey_q  = GROUP_KEY;
      next_st.nkey_q  = NUM_KEY;
      next_st.rkey_q  = r_both;
      next_st.fault_q = fault;

      // fixed rate clocking enable
      if (st.bcnt >= BAUD_CYCLES - 16'h0001) begin
         next_st.bcnt      = 16'h0000;
         next_st.baud_tick = 1'b1;
      end else begin
         next_st.bcnt = st.bcnt + 16'h0001;
      end

      // bus write: address and data taken in either order
      if (st.rsp.bvalid && AXI_REQ.bready)
         next_st.rsp.bvalid = 1'b0;
      if (st.rsp.awready && AXI_REQ.awvalid) begin
         next_st.aw_got  = 1'b1;
         next_st.aw_addr = AXI_REQ.awaddr;
      end
      if (st.rsp.wready && AXI_REQ.wvalid) begin
         next_st.w_got  = 1'b1;
         next_st.w_data = AXI_REQ.wdata;
         next_st.w_strb = AXI_REQ.wstrb;
      end
      if (next_st.aw_got && next_st.w_got && !st.rsp.bvalid) begin
         next_st.aw_got     = 1'b0;
         next_st.w_got      = 1'b0;
         next_st.rsp.bvalid = 1'b1;
         next_st.rsp.bresp  = mapped(next_st.aw_addr) ? ssp_pkg::RESP_OKAY
                                                       : ssp_pkg::RESP_DECERR;
         if (next_st.aw_addr == ssp_pkg::REG_SETTINGS) begin
            for (int i = 0; i < 3; i++) begin
               if (next_st.w_strb[i])
                  next_st.grp[i] = next_st.w_data[8*i +: 8];
            end
         end
         if (next_st.aw_addr == ssp_pkg::REG_STATUS && next_st.w_strb[0] &&
             next_st.w_data[ssp_pkg::STAT_ERR])
            next_st.err_flag = 1'b0;
      end
      next_st.rsp.awready = !next_st.aw_got && !next_st.rsp.bvalid;
      next_st.rsp.wready  = !next_st.w_got && !next_st.rsp.bvalid;

      // bus read: one cycle after the address is taken
      if (st.rsp.rvalid && AXI_REQ.rready)
         next_st.rsp.rvalid = 1'b0;
      if (st.rsp.arready && AXI_REQ.arvalid) begin
         next_st.rsp.rvalid = 1'b1;
         next_st.rsp.rdata  = read_word(st, AXI_REQ.araddr);
         next_st.rsp.rresp  = mapped(AXI_REQ.araddr) ? ssp_pkg::RESP_OKAY
                                                      : ssp_pkg::RESP_DECERR;
      end
      next_st.rsp.arready = !next_st.rsp.rvalid;

      // storage fault edge: message request, sticky flag beats a clear
      if (fault && !st.fault_q) begin
         next_st.con_msg  = 1'b1;
         next_st.err_flag = 1'b1;
      end

      // panel sequencing
      unique case (st.mode)
         ssp_pkg::ST_LOAD: begin
            next_st.grp = NV_IMAGE;
            if (NV_IMAGE[ssp_pkg::SEL_COLD]) begin
               next_st.grp[ssp_pkg::GRP_ONE]   = ssp_pkg::FACT_GRP1;
               next_st.grp[ssp_pkg::GRP_TWO]   = ssp_pkg::FACT_GRP2;
               next_st.grp[ssp_pkg::GRP_THREE] = ssp_pkg::FACT_GRP3;
               next_st.lgn = NV_IMAGE[11:8];
            end
            next_st.mode = ssp_pkg::ST_STATUS;
         end
         ssp_pkg::ST_PANEL_RST: begin
            if (st.rcnt <= 16'h0001)
               next_st.mode = ssp_pkg::ST_LOAD;
            else
               next_st.rcnt = st.rcnt - 16'h0001;
         end
         ssp_pkg::ST_STATUS,
         ssp_pkg::ST_EDIT: begin
            if (r_both && !st.rkey_q) begin
               next_st.store_req = 1'b1;
               next_st.mode      = ssp_pkg::ST_PANEL_RST;
               next_st.rcnt      = ssp_pkg::PANEL_RST_CYC;
            end else if (g_press != 3'h0) begin
               next_st.sel   = first_key(g_press);
               next_st.mode  = ssp_pkg::ST_EDIT;
               next_st.timer = TIMEOUT_CYCLES;
            end else if (st.mode == ssp_pkg::ST_EDIT) begin
               if (k_press != 8'h00) begin
                  next_st.grp[st.sel] = next_st.grp[st.sel] ^ k_press;
                  next_st.timer       = TIMEOUT_CYCLES;
               end else if (st.timer <= 32'h0000_0001) begin
                  next_st.mode      = ssp_pkg::ST_STATUS;
                  next_st.store_req = 1'b1;
               end else begin
                  next_st.timer = st.timer - 32'h0000_0001;
               end
            end
         end
      endcase

      // indicators, one selection per indicator in fixed order
      unique case (next_st.mode)
         ssp_pkg::ST_EDIT:      next_st.ind = next_st.grp[next_st.sel];
         ssp_pkg::ST_PANEL_RST: next_st.ind = ssp_pkg::IND_ALL_ON;
         ssp_pkg::ST_LOAD:      next_st.ind = ssp_pkg::IND_ALL_ON;
         ssp_pkg::ST_STATUS:    next_st.ind = STATUS_IND;
      endcase

      // configuration decoded from the switch groups
      next_st.cfg.pkt_mod128 = next_st.grp[ssp_pkg::GRP_ONE][ssp_pkg::SEL_PKT];
      next_st.cfg.frm_mod128 = next_st.grp[ssp_pkg::GRP_ONE][ssp_pkg::SEL_FRM];
      next_st.cfg.dce_role   = next_st.grp[ssp_pkg::GRP_ONE][ssp_pkg::SEL_DCE];
      next_st.cfg.cold_start = next_st.grp[ssp_pkg::GRP_ONE][ssp_pkg::SEL_COLD];
      next_st.cfg.lgn        = next_st.lgn;
      if (next_st.lgn == 4'h0) begin
         next_st.cfg.lcn_first = 5'h01;
         next_st.cfg.lcn_last  = CHAN_COUNT + 5'h02;
      end else begin
         next_st.cfg.lcn_first = 5'h00;
         next_st.cfg.lcn_last  = CHAN_COUNT + 5'h01;
      end
      next_st.cfg.bias_en = bias_map(next_st.grp[ssp_pkg::GRP_THREE]);

      // channel control inputs: driven level, else the bank bias
      next_st.ctl = (CTL_DRIVEN & CTL_LEVEL) | (~CTL_DRIVEN & next_st.cfg.bias_en);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST)
         st <= '0;
      else
         st <= next_st;
   end

   // outputs straight from the state register
   assign AXI_RSP     = st.rsp;
   assign INDICATOR   = st.ind;
   assign STORE_REQ   = st.store_req;
   assign STORE_DATA  = st.grp;
   assign CONSOLE_MSG = st.con_msg;
   assign PANEL_RESET = (st.mode == ssp_pkg::ST_PANEL_RST);
   assign CTL_STATE   = st.ctl;
   assign BAUD_TICK   = st.baud_tick;
   assign CFG         = st.cfg;

endmodule // ssp_panel

`default_nettype wire

// ==== ssp_pkg.sv ====
// shared constants, bus carriers and state type of the soft switch panel
package ssp_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam longint CLK_HZ          = 100_000_000;
   localparam longint TIMEOUT_S       = 25;             // display timeout, seconds
   localparam logic [31:0] TIMEOUT_CYC = 32'(TIMEOUT_S * CLK_HZ);
   localparam longint BAUD_BPS        = 9600;           // fixed clocking rate
   localparam logic [15:0] BAUD_CYC   = 16'(CLK_HZ / BAUD_BPS);
   localparam longint PANEL_RST_US    = 10;             // panel reset hold, microseconds
   localparam logic [15:0] PANEL_RST_CYC = 16'((PANEL_RST_US * CLK_HZ) / 1_000_000);

   // ----------------------------------------------------------------
   // register map and bus answers
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_SETTINGS = 4'h0;
   localparam logic [3:0] REG_STATUS   = 4'h4;
   localparam logic [3:0] REG_CIRCUIT  = 4'h8;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_DECERR  = 2'h3;
   localparam int STAT_EDIT  = 0;
   localparam int STAT_GRP   = 1;     // two bits
   localparam int STAT_PRST  = 3;
   localparam int STAT_ERR   = 4;     // sticky, write one to clear

   // ----------------------------------------------------------------
   // switch groups, selection positions and factory values
   // ----------------------------------------------------------------
   localparam int GRP_ONE    = 0;
   localparam int GRP_TWO    = 1;
   localparam int GRP_THREE  = 2;
   localparam int SEL_COLD   = 3;     // group one selection 4
   localparam int SEL_PKT    = 4;     // group one selection 5
   localparam int SEL_FRM    = 6;     // group one selection 7
   localparam int SEL_DCE    = 7;     // group one selection 8
   localparam int SEL_BIAS_A = 5;     // group three selections 6..8
   localparam int SEL_BIAS_B = 6;
   localparam int SEL_BIAS_C = 7;
   localparam int BANK_A_END = 3;     // channels 1..4
   localparam int BANK_B_END = 9;     // channels 5..10
   localparam logic [7:0] FACT_GRP1 = 8'h00;
   localparam logic [7:0] FACT_GRP2 = 8'h00;
   localparam logic [7:0] FACT_GRP3 = 8'h00;
   localparam logic [7:0] IND_ALL_ON = 8'hFF;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        awvalid;
      logic [3:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [3:0]  araddr;
      logic        rready;
   } ssp_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ssp_axi_rsp_t;

   typedef struct packed {
      logic        pkt_mod128;
      logic        frm_mod128;
      logic        dce_role;
      logic        cold_start;
      logic [3:0]  lgn;
      logic [4:0]  lcn_first;
      logic [4:0]  lcn_last;
      logic [15:0] bias_en;
   } ssp_cfg_t;

   typedef enum logic [1:0] {ST_LOAD, ST_STATUS, ST_EDIT, ST_PANEL_RST} ssp_mode_t;

   typedef struct packed {
      ssp_mode_t      mode;
      logic [2:0][7:0] grp;
      logic [1:0]     sel;
      logic [31:0]    timer;
      logic [15:0]    rcnt;
      logic [15:0]    bcnt;
      logic [3:0]     lgn;
      logic [2:0]     gkey_q;
      logic [7:0]     nkey_q;
      logic           rkey_q;
      logic           fault_q;
      logic           err_flag;
      logic           aw_got;
      logic [3:0]     aw_addr;
      logic           w_got;
      logic [31:0]    w_data;
      logic [3:0]     w_strb;
      ssp_axi_rsp_t   rsp;
      logic [7:0]     ind;
      logic [15:0]    ctl;
      logic           store_req;
      logic           con_msg;
      logic           baud_tick;
      ssp_cfg_t       cfg;
   } ssp_state_t;

endpackage

// ==== tb_top.sv ====
// self-checking bench for the soft switch panel
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [31:0] TO = 32'h00000032; // shortened timeout
   logic                  CORE_CLK = 1'b0;
   logic                  SYS_RST = 1'b1;
   ssp_pkg::ssp_axi_req_t req = '0;
   ssp_pkg::ssp_axi_rsp_t rsp;
   ssp_pkg::ssp_cfg_t     cfg;
   logic [2:0]            gk = 3'h0;
   logic [7:0]            nk = 8'h00, sind = 8'hA5, ind, m;
   logic                  ra = 1'b0, rb = 1'b0, serr = 1'b0, blow = 1'b0;
   logic [15:0]           cdrv = 16'h0000, clev = 16'h0000, cst;
   logic [23:0]           nv, sdata, img, exp_q[$];
   logic                  sreq, cmsg, prst, btick;
   logic [31:0]           rd;
   logic [1:0]            rs;
   logic [4:0]            chn = 5'h10;
   int                    num_errors = 0, num_checks = 0, n;
   // clock
   always #5 CORE_CLK = ~CORE_CLK;
   ssp_panel #(.TIMEOUT_CYCLES(TO), .BAUD_CYCLES(16'h0008)) u_dut (
      .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .AXI_REQ(req), .AXI_RSP(rsp),
      .GROUP_KEY(gk), .NUM_KEY(nk), .RESET_KEY_A(ra), .RESET_KEY_B(rb),
      .STATUS_IND(sind), .INDICATOR(ind), .NV_IMAGE(nv), .STORE_REQ(sreq),
      .STORE_DATA(sdata), .STORE_ERR(serr), .BATT_LOW(blow), .CONSOLE_MSG(cmsg),
      .PANEL_RESET(prst), .CHAN_COUNT(chn), .CTL_DRIVEN(cdrv), .CTL_LEVEL(clev),
      .CTL_STATE(cst), .BAUD_TICK(btick), .CFG(cfg));
   ssp_nv_model u_nv (.CORE_CLK(CORE_CLK), .STORE_REQ(sreq), .STORE_DATA(sdata),
      .NV_IMAGE(nv));
   task automatic clk(input int c);
      repeat (c) @(posedge CORE_CLK);
   endtask
   task automatic chk(input logic ok, input string what);
      num_checks++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("FAIL at %0t: %s", $time, what);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // one bus transfer, valids held until each channel is taken
   task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      req <= '{awvalid:wr, awaddr:a, wvalid:wr, wdata:d, wstrb:4'hF, bready:wr,
               arvalid:!wr, araddr:a, rready:!wr};
      for (int i = 0; i < 40 && !done; i++) begin
         @(posedge CORE_CLK);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.bvalid || rsp.rvalid) begin
            done = 1'b1;
            rd = rsp.rdata;
            rs = wr ? rsp.bresp : rsp.rresp;
            req.bready <= 1'b0;
            req.rready <= 1'b0;
         end
      end
      if (!done) begin
         chk(1'b0, "bus hang");
         wrap_up();
      end else begin
         clk(1); // release settles before the next request
      end
   endtask
   // press and release keys
   task automatic key(input logic [2:0] g, input logic [7:0] k);
      gk <= g;
      nk <= k;
      clk(2);
      gk <= 3'h0;
      nk <= 8'h00;
      clk(2);
   endtask
   // compare each commit against the oldest expected image
   always @(posedge CORE_CLK) begin
      if (sreq === 1'b1) begin
         if (exp_q.size() == 0) chk(1'b0, "unexpected store");
         else chk(sdata === exp_q.pop_front(), "stored image");
      end
   end
   // watchdog
   initial begin
      #500000;
      chk(1'b0, "run timeout");
      wrap_up();
   end
   initial begin
      void'($urandom(32'h9207ce72));
      clk(16);
      SYS_RST <= 1'b0;
      sind <= 8'($urandom());
      chn  <= 5'h04 + 5'($urandom() % 13);
      clk(3);
      chk(cfg.lcn_first === 5'h01 && cfg.lcn_last === chn + 5'h02,
          "default circuits");
      axi(1'b0, 4'hC, 32'h0);
      chk(rs === ssp_pkg::RESP_DECERR, "unmapped read");
      axi(1'b1, 4'hC, 32'hFF);
      chk(rs === ssp_pkg::RESP_DECERR, "unmapped write");
      img = 24'h000031;
      axi(1'b1, ssp_pkg::REG_SETTINGS, {8'h00, img});
      axi(1'b0, ssp_pkg::REG_SETTINGS, 32'h0);
      chk(rd[23:0] === img, "settings readback");
      key(3'h1, 8'h00);
      chk(ind === img[7:0], "group one shown");
      m = 8'($urandom()) & 8'hC7;
      key(3'h0, m);
      img[7:0] ^= m;
      chk(ind === img[7:0], "toggle");
      key(3'h2, 8'h00);
      chk(ind === img[15:8], "group two shown");
      key(3'h0, 8'h0F);
      img[15:8] ^= 8'h0F;
      key(3'h1, 8'h00);
      chk(ind === img[7:0], "group one kept");
      key(3'h4, 8'h00);
      clk(30);
      key(3'h0, 8'hE2);
      img[23:16] ^= 8'hE2;
      chk(ind === img[23:16], "group three toggled");
      exp_q.push_back(img);
      for (n = 0; n < 200 && sreq !== 1'b1; n++) clk(1);
      chk(n >= TO - 32'h8 && n <= TO + 32'h2, "timeout length");
      clk(2);
      chk(ind === sind, "status shown");
      key(3'h0, 8'hFF);
      chk(ind === sind && sdata === img, "key outside edit");
      serr <= 1'b1;
      clk(2);
      chk(cmsg === 1'b1, "console message");
      clk(1);
      serr <= 1'b0;
      axi(1'b0, ssp_pkg::REG_STATUS, 32'h0);
      chk(rd[ssp_pkg::STAT_ERR] === 1'b1, "fault flag");
      axi(1'b1, ssp_pkg::REG_STATUS, 32'h10);
      axi(1'b0, ssp_pkg::REG_STATUS, 32'h0);
      chk(rd[ssp_pkg::STAT_ERR] === 1'b0, "fault clear");
      blow <= 1'b1;
      clk(3);
      blow <= 1'b0;
      img = 24'hE00408;
      axi(1'b1, ssp_pkg::REG_SETTINGS, {8'h00, img});
      exp_q.push_back(img);
      ra <= 1'b1;
      rb <= 1'b1;
      clk(3);
      chk(prst === 1'b1 && ind === ssp_pkg::IND_ALL_ON, "lamps in panel reset");
      ra <= 1'b0;
      rb <= 1'b0;
      for (n = 0; n < 2000 && prst !== 1'b0; n++) clk(1);
      chk(n < 2000, "panel reset stuck");
      clk(4);
      chk(sdata === {ssp_pkg::FACT_GRP3, ssp_pkg::FACT_GRP2, ssp_pkg::FACT_GRP1},
          "cold start factory");
      chk(cfg.lgn === 4'h4, "group number");
      chk(cfg.lcn_first === 5'h00 && cfg.lcn_last === chn + 5'h01,
          "nonzero group circuits");
      axi(1'b0, ssp_pkg::REG_CIRCUIT, 32'h0);
      chk(rd[13:0] === {chn + 5'h01, 5'h00, 4'h4}, "circuit register");
      axi(1'b1, ssp_pkg::REG_SETTINGS, 32'h00600000);
      repeat (8) begin
         cdrv <= 16'($urandom());
         clev <= 16'($urandom());
         clk(3);
         chk(cst === ((cdrv & clev) | (~cdrv & 16'h03FF)), "bias");
      end
      clk(5);
      chk(exp_q.size() == 0, "store missing");
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
